/* File: logic/mpm_multiplier.sv */
// Registered 16x16 multiplier with APB control, a dedicated product port and a shared Y port
//
// Implementation choices: the APB interface to the registers and the register offsets.
`default_nettype none
//
// Contract
// - Multiply two 16-bit operands into a full 32-bit product, two words.
// - Each operand signed or unsigned by its own select; mixing allowed.
// - Each operand and product register loads on its own strobe's rise.
// - Dedicated product port shows upper or lower word, one at a time.
// - Lower word may be driven onto the Y port; host must not drive then.
// - Every product driver can release its lines (port enable low, lower enable high).
// - Bypass mode passes array result through instead of the held words.
// - Y loads only while lower enable high; low drives the lower word.
// - Route select high puts lower word on product port; port needs enable.
// - Shift control low drops duplicate sign, shifts upper word up one.
// - Four separate load strobes: X, Y, lower product, upper product.
module mpm_multiplier
  import mpm_pkg::*;
(
  // APB clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic [MPM_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Operand pins
  input  wire logic [MPM_OP_W-1:0]   x_data_in,
  input  wire logic [MPM_OP_W-1:0]   y_data_in,
  // Shared Y port, lower word output side
  output logic      [MPM_OP_W-1:0]   y_data_out,
  output logic                       y_data_oe,
  // Dedicated product port
  output logic      [MPM_OP_W-1:0]   product_out,
  output logic                       product_oe,
  // Load strobes
  input  wire logic                  x_load_clk,
  input  wire logic                  y_load_clk,
  input  wire logic                  lower_load_clk,
  input  wire logic                  upper_load_clk
);
  localparam int SW = 2 * MPM_OP_W + MPM_NUM_STROBE;

  logic [SW-1:0]             sync_q;
  logic [MPM_NUM_STROBE-1:0] strobe_d;
  logic [MPM_CTRL_W-1:0]     ctrl;
  logic [MPM_OP_W-1:0]       x_op;
  logic [MPM_OP_W-1:0]       y_op;
  logic                      x_signed;
  logic                      y_signed;
  logic [MPM_OP_W-1:0]       lower_word;
  logic [MPM_OP_W-1:0]       upper_word;
  logic signed [33:0]        full_product;

  wire  [MPM_OP_W-1:0]       x_s;
  wire  [MPM_OP_W-1:0]       y_s;
  wire  [MPM_NUM_STROBE-1:0] strobe_s;
  wire  [MPM_NUM_STROBE-1:0] strobe_rise;
  wire  signed [16:0]        x_ext;
  wire  signed [16:0]        y_ext;
  wire  [31:0]               prod;
  wire  [MPM_OP_W-1:0]       upper_arr;
  wire  [MPM_OP_W-1:0]       lower_arr;
  wire  [MPM_OP_W-1:0]       upper_sel;
  wire  [MPM_OP_W-1:0]       lower_sel;
  wire                       y_accept;
  wire                       apb_setup;
  wire                       apb_done;
  wire                       apb_wr;
  wire                       hit_ctrl;
  wire                       hit_prod;
  wire                       hit_xop;
  wire                       hit_yop;
  wire                       hit_any;
  wire  [31:0]               rd_mux;

  // Pins come from outside the clock domain
  mpm_sync #(
    .W (SW)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({upper_load_clk, lower_load_clk, y_load_clk, x_load_clk,
                y_data_in, x_data_in}),
    .q       (sync_q)
  );

  assign x_s      = sync_q[MPM_OP_W-1:0];
  assign y_s      = sync_q[2*MPM_OP_W-1:MPM_OP_W];
  assign strobe_s = sync_q[SW-1:2*MPM_OP_W];

  // Data and strobes pass equal stages, so data is aligned with its edge
  assign strobe_rise = strobe_s & ~strobe_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strobe_d <= '0;
    else
      strobe_d <= strobe_s;
  end

  // Y pins carry our own lower word while the port is turned round
  assign y_accept = ctrl[MPM_B_LOWER_OEN];

  // Format selects are captured with their operand
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x_op     <= '0;
      x_signed <= 1'b0;
    end
    else if (strobe_rise[MPM_S_X])
    begin
      x_op     <= x_s;
      x_signed <= ctrl[MPM_B_XSIGNED];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      y_op     <= '0;
      y_signed <= 1'b0;
    end
    else if (strobe_rise[MPM_S_Y] && y_accept)
    begin
      y_op     <= y_s;
      y_signed <= ctrl[MPM_B_YSIGNED];
    end
  end

  // Seventeenth bit makes one signed multiply cover every mode
  assign x_ext = {x_signed & x_op[MPM_OP_W-1], x_op};
  assign y_ext = {y_signed & y_op[MPM_OP_W-1], y_op};

  always_comb
  begin
    full_product = x_ext * y_ext;
  end

  assign prod = full_product[31:0];

  // Shifted form keeps the duplicated sign at the top of the lower word
  assign upper_arr = ctrl[MPM_B_SHIFT] ? prod[31:16]
                                       : prod[30:15];
  assign lower_arr = ctrl[MPM_B_SHIFT] ? prod[15:0]
                                       : {prod[30], prod[14:0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lower_word <= '0;
    else if (strobe_rise[MPM_S_LOWER])
      lower_word <= lower_arr;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      upper_word <= '0;
    else if (strobe_rise[MPM_S_UPPER])
      upper_word <= upper_arr;
  end

  // Transparent mode still costs one cycle: outputs must be registered
  assign lower_sel = ctrl[MPM_B_BYPASS] ? lower_arr : lower_word;
  assign upper_sel = ctrl[MPM_B_BYPASS] ? upper_arr : upper_word;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      product_out <= '0;
      product_oe  <= 1'b0;
      y_data_out  <= '0;
      y_data_oe   <= 1'b0;
    end
    else
    begin
      product_out <= ctrl[MPM_B_ROUTE] ? lower_sel : upper_sel;
      product_oe  <= ctrl[MPM_B_PORT_EN];
      y_data_out  <= lower_sel;
      y_data_oe   <= ~ctrl[MPM_B_LOWER_OEN];
    end
  end

  // APB decode
  assign apb_setup = psel & penable & ~pready;
  assign apb_done  = psel & penable & pready;
  assign apb_wr    = apb_done & pwrite;
  assign hit_ctrl  = (paddr == MPM_OFF_CTRL);
  assign hit_prod  = (paddr == MPM_OFF_PROD);
  assign hit_xop   = (paddr == MPM_OFF_XOP);
  assign hit_yop   = (paddr == MPM_OFF_YOP);
  assign hit_any   = hit_ctrl | hit_prod | hit_xop | hit_yop;

  assign rd_mux = hit_ctrl ? {25'h0000000, ctrl}
                : hit_prod ? {upper_sel, lower_sel}
                : hit_xop  ? {15'h0000, x_signed, x_op}
                : hit_yop  ? {15'h0000, y_signed, y_op}
                : 32'h00000000;

  // Control writes only through byte lane 0, where every field sits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= MPM_CTRL_RESET;
    else if (apb_wr && hit_ctrl && pstrb[0])
      ctrl <= pwdata[MPM_CTRL_W-1:0];
  end

  // One wait state lets pready, prdata and pslverr come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (apb_setup)
    begin
      pready  <= 1'b1;
      pslverr <= ~hit_any;
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
  end
endmodule
`default_nettype wire

/* File: logic/mpm_pkg.sv */
// Constants shared by the registered 16x16 multiplier
`default_nettype none
package mpm_pkg;
  localparam int          MPM_OP_W        = 16;
  localparam int          MPM_ADDR_W      = 12;
  localparam int          MPM_NUM_STROBE  = 4;
  // Register byte offsets
  localparam logic [11:0] MPM_OFF_CTRL    = 12'h000;
  localparam logic [11:0] MPM_OFF_PROD    = 12'h004;
  localparam logic [11:0] MPM_OFF_XOP     = 12'h008;
  localparam logic [11:0] MPM_OFF_YOP     = 12'h00C;
  // Control field positions
  localparam int          MPM_CTRL_W      = 7;
  localparam int          MPM_B_XSIGNED   = 0;
  localparam int          MPM_B_YSIGNED   = 1;
  localparam int          MPM_B_SHIFT     = 2;
  localparam int          MPM_B_BYPASS    = 3;
  localparam int          MPM_B_ROUTE     = 4;
  localparam int          MPM_B_PORT_EN   = 5;
  localparam int          MPM_B_LOWER_OEN = 6;
  // Reset: Y port in input mode, product port released
  localparam logic [6:0]  MPM_CTRL_RESET  = 7'h40;
  // Strobe positions within the strobe group
  localparam int          MPM_S_X         = 0;
  localparam int          MPM_S_Y         = 1;
  localparam int          MPM_S_LOWER     = 2;
  localparam int          MPM_S_UPPER     = 3;
  // Synchroniser depth
  localparam int          MPM_SYNC_STAGES = 2;
endpackage
`default_nettype wire

/* File: logic/mpm_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module mpm_sync
  import mpm_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Pins and synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: bench/mpm_chk.sv */
// Assertions on the multiplier's bus answers and port enables
`default_nettype none
module mpm_chk
  import mpm_pkg::*;
(
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic [MPM_ADDR_W-1:0] paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Port enables
  input wire logic                  y_data_oe,
  input wire logic                  product_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  chk_one_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("answer not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_phase: assert property (pready |-> s_access)
    else $error("ready outside access phase");
  chk_err_decode: assert property (pready |-> (pslverr == !(paddr ==
    MPM_OFF_CTRL || paddr == MPM_OFF_PROD || paddr == MPM_OFF_XOP ||
    paddr == MPM_OFF_YOP))) else $error("bad error answer");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_xop_pad: assert property (
    pready && !pwrite && paddr == MPM_OFF_XOP |-> prdata[31:17] == 15'h0)
    else $error("operand pad bits set");
  // Enables follow the write edge by one cycle, seen one sample later
  chk_yoe_hold: assert property (
    !$past(pready, 2) |-> $stable(y_data_oe))
    else $error("Y enable moved without write");
  chk_poe_hold: assert property (
    !$past(pready, 2) |-> $stable(product_oe))
    else $error("port enable moved without write");
endmodule
bind mpm_multiplier mpm_chk chk_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .y_data_oe(y_data_oe), .product_oe(product_oe));
`default_nettype wire

/* File: bench/mpm_host.sv */
// Host model driving operand pins and load strobes
`default_nettype none
module mpm_host
  import mpm_pkg::*;
(
  // Clock
  input  wire logic   pclk,
  // Operand pins and strobes
  output logic [15:0] x_pin,
  output logic [15:0] y_drv,
  output logic [3:0]  stb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    x_pin = '0;
    y_drv = '0;
    stb = '0;
  end
  // Data outlives the synchroniser delay, then is scrambled
  task automatic load(input int i, input logic [15:0] v);
    if (i == MPM_S_X) x_pin <= v;
    if (i == MPM_S_Y) y_drv <= v;
    @(posedge pclk);
    stb[i] <= 1'b1;
    repeat (4) @(posedge pclk);
    stb[i] <= 1'b0;
    repeat (3) @(posedge pclk);
    if (i == MPM_S_X) x_pin <= ~v;
    if (i == MPM_S_Y) y_drv <= ~v;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the registered multiplier
`default_nettype none
module tb_top
  import mpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, y_data_oe, product_oe;
  logic [15:0] x_data_in, y_data_in, y_data_out, product_out, y_drv;
  logic [3:0]  stb;
  logic [3:0]  pstrb = 4'hF;
  int          miscompares = 0, num_checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  assign y_data_in = y_data_oe ? y_data_out : y_drv;
  mpm_multiplier dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .x_data_in(x_data_in), .y_data_in(y_data_in), .y_data_out(y_data_out),
    .y_data_oe(y_data_oe), .product_out(product_out),
    .product_oe(product_oe), .x_load_clk(stb[MPM_S_X]),
    .y_load_clk(stb[MPM_S_Y]), .lower_load_clk(stb[MPM_S_LOWER]),
    .upper_load_clk(stb[MPM_S_UPPER]));
  mpm_host host_u (.pclk(pclk), .x_pin(x_data_in), .y_drv(y_drv), .stb(stb));
  task automatic check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Answer taken at the edge that samples pready high, then freed
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] prod(input logic [15:0] x, y,
                                       input logic xs, ys, sh);
    logic signed [33:0] p;
    p = $signed({xs & x[15], x}) * $signed({ys & y[15], y});
    return sh ? p[31:0] : {p[30:15], p[30], p[14:0]};
  endfunction
  task automatic t_bus;
    apb(0, MPM_OFF_CTRL, 0, rd);
    check(rd, 32'h40);
    check(product_oe, 0);
    pstrb <= 4'h0;
    apb(1, MPM_OFF_CTRL, 32'h0000007F, rd);
    pstrb <= 4'hF;
    apb(0, MPM_OFF_CTRL, 0, rd);
    check(rd, 32'h40);
    apb(0, 12'h010, 0, rd);
    check(err, 1);
    check(rd, 0);
    apb(1, MPM_OFF_PROD, 32'hFFFFFFFF, rd);
    apb(0, MPM_OFF_PROD, 0, rd);
    check(err, 0);
    check(rd, 0);
    $display("bus test done");
  endtask
  task automatic t_modes;
    logic [15:0] xv [4] = '{16'h8000, 16'h8000, 16'hFFFF, 16'hFFFF};
    logic [15:0] yv [4] = '{16'h8000, 16'h8000, 16'hFFFF, 16'h8000};
    logic [2:0]  md [4] = '{3'b011, 3'b111, 3'b100, 3'b110};
    logic [31:0] e;
    for (int i = 0; i < 4; i++)
    begin
      apb(1, MPM_OFF_CTRL, {25'h0, 4'hD, md[i]}, rd);
      host_u.load(MPM_S_X, xv[i]);
      host_u.load(MPM_S_Y, yv[i]);
      e = prod(xv[i], yv[i], md[i][0], md[i][1], md[i][2]);
      apb(0, MPM_OFF_PROD, 0, rd);
      check(rd, e);
      check({product_oe, product_out}, {1'b1, e[31:16]});
      apb(0, MPM_OFF_XOP, 0, rd);
      check(rd, {15'h0, md[i][0], xv[i]});
      apb(1, MPM_OFF_CTRL, {25'h0, 4'hF, md[i]}, rd);
      @(posedge pclk);
      check(product_out, e[15:0]);
    end
    $display("mode test done");
  endtask
  task automatic t_held;
    logic [31:0] e0, e1;
    e0 = prod(16'h1234, 16'h0100, 0, 0, 1);
    e1 = prod(16'hABCD, 16'h0100, 0, 0, 1);
    apb(1, MPM_OFF_CTRL, 32'h64, rd);
    host_u.load(MPM_S_X, 16'h1234);
    host_u.load(MPM_S_Y, 16'h0100);
    host_u.load(MPM_S_LOWER, 0);
    host_u.load(MPM_S_UPPER, 0);
    host_u.load(MPM_S_X, 16'hABCD);
    apb(0, MPM_OFF_PROD, 0, rd);
    check(rd, e0);
    host_u.load(MPM_S_LOWER, 0);
    apb(0, MPM_OFF_PROD, 0, rd);
    check(rd, {e0[31:16], e1[15:0]});
    host_u.load(MPM_S_UPPER, 0);
    apb(0, MPM_OFF_PROD, 0, rd);
    check(rd, e1);
    $display("held test done");
  endtask
  task automatic t_ypath;
    apb(1, MPM_OFF_CTRL, 32'h04, rd);
    @(posedge pclk);
    check({y_data_oe, product_oe}, 2'b10);
    check(y_data_out, 16'hCD00);
    host_u.load(MPM_S_Y, 16'h7777);
    apb(0, MPM_OFF_YOP, 0, rd);
    check(rd, 32'h100);
    apb(1, MPM_OFF_CTRL, 32'h40, rd);
    @(posedge pclk);
    check(y_data_oe, 0);
    $display("Y port test done");
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      miscompares++;
      results;
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus;
    t_modes;
    t_held;
    t_ypath;
    results;
  end
endmodule
`default_nettype wire
